/* File: ooc_top.sv */
// On/off cycle controller for a flyback converter: main switch, limit
// selection and synchronous rectifier drive.
// Assumes comparator levels from analog sense circuits and a 20 MHz clock.
// Notes on behaviour
// - An enabled period turns the main gate on at its start.
// - Gate turns off at current limit or maximum duty, whichever first.
// - Oscillator runs always; feedback sampled each period to fire or skip.
// - A started cycle always completes; later feedback cannot cut it short.
// - A state machine picks the current limit from recent fire/skip history.
// - Many fires select the highest limit; fewer fires step limits down.
// - Exactly four limit states, each with its own current limit.
// - In continuous conduction rectifier turns off at next request, on the same edge the main gate turns on.
// - In discontinuous conduction rectifier turns off at the threshold comparator.
// - Rectifier turns on from the winding sense input.
// - Low output in current mode forces auto-restart until load drops.
// - Above current threshold, pulse requests are cut to hold current fixed.
// - Below current threshold, feedback comparator decides pulse requests.
// - Voltage mode requests cycles to hold feedback at reference.
// - Rectifier and main switch never conduct together.
// - Rectifier enabled only after a requested cycle and winding falling edge.
// - Current surge keeps rectifier drive off until it subsides.
`timescale 1ns/1ps
module ooc_top (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_fb_below_ref,
  input wire logic i_ilim_reached,
  input wire logic i_rectifier_off_threshold,
  input wire logic i_cc_sense_threshold,
  input wire logic i_cc_surge,
  input wire logic i_winding_high,
  input wire logic i_vout_low,
  output logic o_main_gate,
  output logic o_sync_rectifier_gate,
  output logic [1:0] o_ilim_sel,
  output logic o_cc_mode,
  output logic o_auto_restart
);
  typedef struct packed {
    logic [ooc_pkg::CNT_W-1:0] cnt;
    logic [ooc_pkg::HIST_W-1:0] hist;
    ooc_pkg::ooc_lim_t lim;
    logic [1:0] ilim_sel;
    logic gate;
    logic sr;
    logic fired;
    logic armed;
    logic wind_d;
    logic ar;
    logic cc;
  } ooc_st_t;

  localparam ooc_st_t ST_RST = '{
    cnt: ooc_pkg::CNT_ZERO,
    hist: ooc_pkg::HIST_RST,
    lim: ooc_pkg::OOC_LIM3,
    ilim_sel: ooc_pkg::ILIM_CODE3,
    gate: 1'b0,
    sr: 1'b0,
    fired: 1'b0,
    armed: 1'b0,
    wind_d: 1'b0,
    ar: 1'b0,
    cc: 1'b0
  };

  ooc_st_t st_reg;
  ooc_st_t st_next;
  ooc_cmp_if cmp ();

  logic fb_s;
  logic ilim_s;
  logic srth_s;
  logic ccs_s;
  logic surge_s;
  logic wind_s;
  logic vlow_s;
  logic period_end;
  logic req;
  logic wind_fall;
  logic [3:0] fires;

  assign cmp.raw = {i_vout_low, i_winding_high, i_cc_surge, i_cc_sense_threshold,
                    i_rectifier_off_threshold, i_ilim_reached, i_fb_below_ref};

  ooc_sync u_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .cmp(cmp.syncer)
  );

  assign fb_s = cmp.sync[ooc_pkg::CMP_FB];
  assign ilim_s = cmp.sync[ooc_pkg::CMP_ILIM];
  assign srth_s = cmp.sync[ooc_pkg::CMP_SRTH];
  assign ccs_s = cmp.sync[ooc_pkg::CMP_CCS];
  assign surge_s = cmp.sync[ooc_pkg::CMP_SURGE];
  assign wind_s = cmp.sync[ooc_pkg::CMP_WIND];
  assign vlow_s = cmp.sync[ooc_pkg::CMP_VLOW];

  assign period_end = (st_reg.cnt == ooc_pkg::CNT_LAST);

  assign req = fb_s && !ccs_s && !st_reg.ar;

  assign wind_fall = st_reg.wind_d && !wind_s;

  always_comb
  begin
    st_next = st_reg;
    fires = 4'h0;
    st_next.wind_d = wind_s;
    st_next.cc = ccs_s;
    if (ccs_s && vlow_s)
    begin
      st_next.ar = 1'b1;
    end
    else if (!ccs_s)
    begin
      st_next.ar = 1'b0;
    end
    if (period_end)
    begin
      st_next.cnt = ooc_pkg::CNT_ZERO;
      st_next.hist = {st_reg.hist[ooc_pkg::HIST_W-2:0], req};
      st_next.fired = req;
      st_next.armed = 1'b0;
      st_next.gate = req;
      fires = 4'($countones(st_next.hist));
      if (fires >= ooc_pkg::FIRE_HI)
      begin
        st_next.lim = ooc_pkg::OOC_LIM3;
      end
      else if (fires >= ooc_pkg::FIRE_MID)
      begin
        st_next.lim = ooc_pkg::OOC_LIM2;
      end
      else if (fires >= ooc_pkg::FIRE_LO)
      begin
        st_next.lim = ooc_pkg::OOC_LIM1;
      end
      else
      begin
        st_next.lim = ooc_pkg::OOC_LIM0;
      end
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 8'h01;
      if (st_reg.gate && (ilim_s || st_reg.cnt == ooc_pkg::CNT_ON_LAST))
      begin
        st_next.gate = 1'b0;
        st_next.armed = st_reg.fired;
      end
    end
    case (st_next.lim)
      ooc_pkg::OOC_LIM0: st_next.ilim_sel = ooc_pkg::ILIM_CODE0;
      ooc_pkg::OOC_LIM1: st_next.ilim_sel = ooc_pkg::ILIM_CODE1;
      ooc_pkg::OOC_LIM2: st_next.ilim_sel = ooc_pkg::ILIM_CODE2;
      default: st_next.ilim_sel = ooc_pkg::ILIM_CODE3;
    endcase
    if (st_reg.armed && wind_fall && !surge_s && !st_reg.gate)
    begin
      st_next.sr = 1'b1;
      st_next.armed = 1'b0;
    end
    if (srth_s)
    begin
      st_next.sr = 1'b0;
    end
    if (period_end && req)
    begin
      st_next.sr = 1'b0;
    end
    if (surge_s)
    begin
      st_next.sr = 1'b0;
      st_next.armed = 1'b0;
    end
    if (st_next.gate)
    begin
      st_next.sr = 1'b0;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      st_reg <= ST_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_main_gate = st_reg.gate;
  assign o_sync_rectifier_gate = st_reg.sr;
  assign o_ilim_sel = st_reg.ilim_sel;
  assign o_cc_mode = st_reg.cc;
  assign o_auto_restart = st_reg.ar;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  sequence seq_fire;
    period_end && req;
  endsequence

  sequence seq_gate_end;
    st_reg.gate && (ilim_s || st_reg.cnt == ooc_pkg::CNT_ON_LAST) && !period_end;
  endsequence

  sequence seq_cv_req;
    period_end && fb_s && !ccs_s && !st_reg.ar;
  endsequence

  sequence seq_sr_cue;
    st_reg.armed && wind_fall && !surge_s && !srth_s && !st_reg.gate && !period_end;
  endsequence

  sequence seq_restart_cue;
    ccs_s && vlow_s;
  endsequence

  sequence seq_sync_run;
    $past(i_rst_n) && $past(i_rst_n, 2);
  endsequence

  a_gate_on_start: assert property ($rose(st_reg.gate) |-> st_reg.cnt == ooc_pkg::CNT_ZERO)
    else $error("Main gate rose away from period start");
  a_gate_off_end: assert property (seq_gate_end |=> !st_reg.gate)
    else $error("Main gate stayed on past limit or duty end");
  a_fire_decision: assert property (seq_fire |=> st_reg.gate && st_reg.fired)
    else $error("Requested period did not fire");
  a_skip_decision: assert property (period_end && !req |=> !st_reg.gate[*2])
    else $error("Skipped period fired");
  a_cycle_completes: assert property (
    st_reg.gate && !ilim_s && st_reg.cnt < ooc_pkg::CNT_ON_LAST |=> st_reg.gate)
    else $error("Cycle aborted early");
  a_lim_from_hist: assert property (
    st_reg.cnt == ooc_pkg::CNT_ZERO && 4'($countones(st_reg.hist)) >= ooc_pkg::FIRE_HI
    |-> st_reg.lim == ooc_pkg::OOC_LIM3 && o_ilim_sel == ooc_pkg::ILIM_CODE3)
    else $error("Heavy load did not select highest limit");
  a_lim_light: assert property (
    st_reg.cnt == ooc_pkg::CNT_ZERO && 4'($countones(st_reg.hist)) < ooc_pkg::FIRE_LO
    |-> st_reg.lim == ooc_pkg::OOC_LIM0)
    else $error("Light load did not select lowest limit");
  a_lim_onehot: assert property ($onehot(st_reg.lim))
    else $error("Limit state not one of four");
  a_sr_ccm_off: assert property (seq_fire |=> !st_reg.sr ##1 !st_reg.sr)
    else $error("Rectifier on at cycle request");
  a_sr_dcm_off: assert property (st_reg.sr && srth_s |=> !st_reg.sr)
    else $error("Rectifier stayed on below threshold");
  a_sr_on_cause: assert property ($rose(st_reg.sr) |-> $past(st_reg.armed && wind_fall))
    else $error("Rectifier on without requested cycle and edge");
  a_ar_no_fire: assert property (st_reg.ar && period_end |=> !st_reg.gate)
    else $error("Cycle fired during auto restart");
  a_cc_skip: assert property (period_end && ccs_s |=> !st_reg.gate)
    else $error("Cycle fired above current threshold");
  a_no_overlap: assert property (!(st_reg.gate && st_reg.sr))
    else $error("Main switch and rectifier on together");
  a_sr_surge: assert property (surge_s |=> !st_reg.sr)
    else $error("Rectifier on during surge");
  a_sr_on_wind: assert property (seq_sr_cue |=> st_reg.sr)
    else $error("Rectifier missed its winding cue");
  a_ar_enter: assert property (seq_restart_cue |=> st_reg.ar)
    else $error("Auto restart not entered at low output");
  a_ar_release: assert property (st_reg.ar && !ccs_s |=> !st_reg.ar)
    else $error("Auto restart held after current fell");
  a_cc_flag: assert property ($past(i_rst_n) |-> o_cc_mode == $past(ccs_s))
    else $error("Current mode flag does not follow comparator");
  a_cv_fire: assert property (seq_cv_req |=> st_reg.gate)
    else $error("Voltage mode request did not fire");
  a_fb_skip: assert property (period_end && !fb_s |=> !st_reg.gate)
    else $error("Period fired with output at reference");
  a_lim_mid: assert property (
    st_reg.cnt == ooc_pkg::CNT_ZERO && 4'($countones(st_reg.hist)) >= ooc_pkg::FIRE_MID
    && 4'($countones(st_reg.hist)) < ooc_pkg::FIRE_HI
    |-> st_reg.lim == ooc_pkg::OOC_LIM2 && o_ilim_sel == ooc_pkg::ILIM_CODE2)
    else $error("Medium load did not select second limit");
  a_lim_low: assert property (
    st_reg.cnt == ooc_pkg::CNT_ZERO && 4'($countones(st_reg.hist)) >= ooc_pkg::FIRE_LO
    && 4'($countones(st_reg.hist)) < ooc_pkg::FIRE_MID
    |-> st_reg.lim == ooc_pkg::OOC_LIM1 && o_ilim_sel == ooc_pkg::ILIM_CODE1)
    else $error("Light load did not select third limit");
  a_sel_steady: assert property (!period_end |=> $stable(o_ilim_sel))
    else $error("Limit code changed inside a period");
  a_sync_delay: assert property (seq_sync_run |-> cmp.sync == $past(cmp.raw, 2))
    else $error("Comparator level not seen two cycles later");
endmodule

/* File: ooc_pkg.sv */
// Constants and types for the on/off flyback cycle controller.
// Assumes a single 20 MHz clock and comparator levels from analog sense circuits.
package ooc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Oscillator period in ns; the value is a plain default.
  localparam int unsigned OSC_PERIOD_NS = 10000;
  localparam int unsigned OSC_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
  // Maximum duty in percent; the value is a plain default.
  localparam int unsigned MAX_DUTY_PCT = 65;
  localparam int unsigned MAX_ON_CYC = (OSC_CYC * MAX_DUTY_PCT) / 100;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(OSC_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ON_LAST = CNT_W'(MAX_ON_CYC - 1);
  localparam int unsigned HIST_W = 8;
  localparam logic [HIST_W-1:0] HIST_RST = 8'hff;
  localparam logic [3:0] FIRE_HI = 4'h7;
  localparam logic [3:0] FIRE_MID = 4'h5;
  localparam logic [3:0] FIRE_LO = 4'h3;
  // Positions of the comparator levels in the synchronised vector.
  localparam int unsigned CMP_FB = 0;
  localparam int unsigned CMP_ILIM = 1;
  localparam int unsigned CMP_SRTH = 2;
  localparam int unsigned CMP_CCS = 3;
  localparam int unsigned CMP_SURGE = 4;
  localparam int unsigned CMP_WIND = 5;
  localparam int unsigned CMP_VLOW = 6;
  localparam int unsigned CMP_N = 7;
  localparam logic [CMP_N-1:0] CMP_RST = 7'h00;
  // Current limit selector codes driven to the analog limit reference.
  localparam logic [1:0] ILIM_CODE0 = 2'h0;
  localparam logic [1:0] ILIM_CODE1 = 2'h1;
  localparam logic [1:0] ILIM_CODE2 = 2'h2;
  localparam logic [1:0] ILIM_CODE3 = 2'h3;
  typedef enum logic [3:0] {
    OOC_LIM0 = 4'h1,
    OOC_LIM1 = 4'h2,
    OOC_LIM2 = 4'h4,
    OOC_LIM3 = 4'h8
  } ooc_lim_t;
endpackage

/* File: ooc_cmp_if.sv */
// Interface carrying raw and synchronised comparator levels.
// Assumes both ends run on the controller clock.
`timescale 1ns/1ps
interface ooc_cmp_if;
  logic [ooc_pkg::CMP_N-1:0] raw;
  logic [ooc_pkg::CMP_N-1:0] sync;
  modport syncer (input raw, output sync);
  modport user (output raw, input sync);
endinterface

/* File: ooc_sync.sv */
// Two-stage synchroniser for the comparator levels.
// Assumes the levels change freely with respect to the clock.
`timescale 1ns/1ps
module ooc_sync (
  input wire logic i_clock,
  input wire logic i_rst_n,
  ooc_cmp_if.syncer cmp
);
  typedef struct packed {
    logic [ooc_pkg::CMP_N-1:0] s1;
    logic [ooc_pkg::CMP_N-1:0] s2;
  } ooc_sync_st_t;

  ooc_sync_st_t st_reg;
  ooc_sync_st_t st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = cmp.raw;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      st_reg <= '{ooc_pkg::CMP_RST, ooc_pkg::CMP_RST};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign cmp.sync = st_reg.s2;
endmodule

/* File: ooc_partner.sv */
// Far-side model: primary current ramp, winding sense and rectifier drop comparators.
// Assumes the controller clock and registered gate outputs from the controller.
`timescale 1ns/1ps
module ooc_partner #(
  parameter int RAMP_BASE = 20,
  parameter int DRAIN_CYC = 30
) (
  input wire logic i_clock,
  input wire logic i_main_gate,
  input wire logic i_sync_rectifier_gate,
  input wire logic [1:0] i_ilim_sel,
  input wire logic i_stall,
  input wire logic i_ccm,
  output logic o_ilim_reached,
  output logic o_winding_high,
  output logic o_rectifier_off_threshold
);
  int on_cnt = 0;
  int sr_cnt = 0;
  // Current ramps while the switch is on; the winding follows the switch.
  always @(posedge i_clock)
  begin
    on_cnt <= i_main_gate ? on_cnt + 1 : 0;
    sr_cnt <= i_sync_rectifier_gate ? sr_cnt + 1 : 0;
    o_winding_high <= i_main_gate;
  end
  // A higher limit code takes longer to reach; a stalled ramp never trips.
  assign o_ilim_reached = i_main_gate && !i_stall && (on_cnt >= RAMP_BASE * (1 + i_ilim_sel));
  // The drop falls below threshold once the secondary energy has drained.
  assign o_rectifier_off_threshold = !i_ccm && (sr_cnt >= DRAIN_CYC);
endmodule

/* File: tb_on_off_flyback_cycle_control.sv */
// Self-checking bench for the on/off cycle controller with a far-side model.
// Assumes a 20 MHz clock and period decisions every 200 cycles after reset.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_on_off_flyback_cycle_control;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fb = 1'b0;
  logic cc = 1'b0;
  logic vl = 1'b0;
  logic surge = 1'b0;
  logic stall = 1'b0;
  logic ccm = 1'b0;
  logic ilim;
  logic wind;
  logic roff;
  logic gate;
  logic sr;
  logic [1:0] sel;
  logic ccmode;
  logic ar;
  logic [7:0] row;
  int fails = 0;
  int n_tests = 0;
  // Columns: feedback, cc, vout low, gate, limit code (2), cc mode, auto restart.
  logic [7:0] rows [15] = '{8'h9c, 8'h0c, 8'h08, 8'h08, 8'h04, 8'hc6, 8'he3, 8'hc3,
                            8'h90, 8'h90, 8'h94, 8'h94, 8'h98, 8'h98, 8'h9c};
  always #25 clk = ~clk;
  ooc_top u_ooc_top (.i_clock(clk), .i_rst_n(rst_n), .i_fb_below_ref(fb),
    .i_ilim_reached(ilim), .i_rectifier_off_threshold(roff), .i_cc_sense_threshold(cc),
    .i_cc_surge(surge), .i_winding_high(wind), .i_vout_low(vl), .o_main_gate(gate),
    .o_sync_rectifier_gate(sr), .o_ilim_sel(sel), .o_cc_mode(ccmode), .o_auto_restart(ar));
  ooc_partner u_ooc_partner (.i_clock(clk), .i_main_gate(gate), .i_sync_rectifier_gate(sr),
    .i_ilim_sel(sel), .i_stall(stall), .i_ccm(ccm), .o_ilim_reached(ilim),
    .o_winding_high(wind), .o_rectifier_off_threshold(roff));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(negedge clk)
  begin
    if (rst_n)
      `CHK(gate & sr, 1'b0)
  end
  initial
  begin
    repeat (8000) @(posedge clk);
    fails++;
    test_done();
  end
  initial
  begin
    cyc(8);
    rst_n <= 1'b1;
    cyc(100);
    for (int i = 0; i < 15; i++)
    begin
      row = rows[i];
      fb <= row[7];
      cc <= row[6];
      vl <= row[5];
      cyc(110);
      @(negedge clk);
      `CHK(gate, row[4])
      `CHK(sel, row[3:2])
      `CHK(ccmode, row[1])
      `CHK(ar, row[0])
      cyc(90);
    end
    rst_n <= 1'b0;
    fb <= 1'b0;
    cc <= 1'b0;
    vl <= 1'b0;
    cyc(8);
    @(negedge clk);
    `CHK({gate, sr, sel, ccmode, ar}, 6'h0c)
    cyc(1);
    rst_n <= 1'b1;
    cyc(100);
    fb <= 1'b1;
    stall <= 1'b1;
    cyc(105);
    fb <= 1'b0;
    cyc(15);
    @(negedge clk);
    `CHK(gate, 1'b1)
    cyc(100);
    @(negedge clk);
    `CHK(gate, 1'b1)
    cyc(25);
    stall <= 1'b0;
    @(negedge clk);
    `CHK(gate, 1'b0)
    `CHK(sr, 1'b1)
    cyc(45);
    fb <= 1'b1;
    ccm <= 1'b1;
    @(negedge clk);
    `CHK(sr, 1'b0)
    cyc(200);
    @(negedge clk);
    `CHK(sr, 1'b1)
    cyc(15);
    surge <= 1'b1;
    @(negedge clk);
    `CHK({gate, sr}, 2'h2)
    cyc(145);
    @(negedge clk);
    `CHK({gate, sr}, 2'h0)
    test_done();
  end
endmodule
